// ==== core/lpbw_pkg.sv ====
// Shared constants and types for the bus-transceiver port block
package lpbw_pkg;

    // Word indices of the registers; byte address is four times the index
    localparam logic [5:0] IDX_PORT = 6'h05;
    localparam logic [5:0] IDX_DIR  = 6'h06;
    localparam logic [5:0] IDX_PU   = 6'h07;
    localparam logic [5:0] IDX_IOC  = 6'h08;
    localparam logic [5:0] IDX_CFG  = 6'h09;
    localparam logic [5:0] IDX_STAT = 6'h0A;
    localparam logic [5:0] IDX_MASK = 6'h0B;

    // Port register layout
    localparam int PORT_TX_BIT = 7;
    localparam int PORT_RX_BIT = 6;
    localparam int NUM_PINS    = 6;

    // Pin numbers with special functions
    localparam int PIN_EXT_INT = 2;
    localparam int PIN_MASTER_CLEAR_N    = 3;
    localparam int PIN_XTAL    = 4;
    localparam int PIN_OSC_IN  = 5;

    // Configuration register layout
    localparam int CFG_OSC_LSB   = 0;
    localparam int CFG_OSC_MSB   = 2;
    localparam int CFG_MASTER_CLEAR_N_BIT  = 3;
    localparam int CFG_INSTR_CLOCK_OUT    = 4;
    localparam int CFG_FN_LSB    = 5;
    localparam int CFG_FN_MSB    = 6;
    localparam int CFG_EDGE_BIT  = 7;

    // Status and mask layout
    localparam int STAT_EXT_BIT = 0;
    localparam int STAT_IOC_BIT = 1;

    // Reset values
    localparam logic [7:0] PORT_RST = 8'hC0;
    localparam logic [5:0] DIR_RST  = 6'h3F;
    localparam logic [5:0] PU_RST   = 6'h00;
    localparam logic [5:0] IOC_RST  = 6'h00;
    localparam logic [7:0] CFG_RST  = 8'h80;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Pins that own a pull-up and a change interrupt
    localparam logic [5:0] PU_PINS  = 6'h0B;
    localparam logic [5:0] IOC_PINS = 6'h0B;

    // Instruction clock is the oscillator divided by four
    localparam int INSTR_DIV = 4;

    typedef enum logic [2:0] {
        low_power_crystal_mode,
        standard_crystal_mode,
        high_speed_crystal_mode,
        external_rc_osc_mode,
        internal_rc_osc_mode
    } lpbw_osc_mode_t;

    typedef enum logic [1:0] {
        fn_gpio,
        fn_timer_clock,
        fn_ext_int
    } lpbw_pin2_fn_t;

endpackage : lpbw_pkg

// ==== core/lpbw_clk_div.sv ====
// Divider producing the instruction clock and its one-cycle enable
`timescale 1ns/1ps
`default_nettype none

module lpbw_clk_div (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Divided outputs
    output logic      instr_clk_o,
    output logic      instr_en_o
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       last_w;

    assign last_w = (cnt_q == 2'(lpbw_pkg::INSTR_DIV - 1));
    assign cnt_d  = last_w ? 2'h0 : cnt_q + 2'h1;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q       <= 2'h0;
            instr_clk_o <= 1'b0;
            instr_en_o  <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            instr_clk_o <= cnt_d[1];
            instr_en_o  <= last_w;
        end
    end

endmodule : lpbw_clk_div

`default_nettype wire

// ==== core/lpbw_port.sv ====
// Bus transceiver port bits, pin multiplexing and wake-up logic
`timescale 1ns/1ps
`default_nettype none

module lpbw_port (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Wishbone slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    // Single-wire bus, open drain
    input  wire logic       bus_line_i,
    output logic            bus_line_o,
    output logic            bus_line_oe_n_o,
    output logic            bus_activity_out_o,
    // Port pins
    input  wire logic [5:0] pin_i,
    output logic [5:0]      pin_o,
    output logic [5:0]      pin_oe_n_o,
    output logic [5:0]      pin_pullup_o,
    // Special functions
    output logic            osc_output_en_o,
    output logic            osc_input_en_o,
    output logic            timer_ext_clock_in_o,
    output logic            master_clear_n_o,
    // Interrupt and wake
    output logic            irq_o,
    output logic            wake_o
);

    // Pin-four role in the given oscillator mode; used for drive and the crystal output enable
    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == lpbw_pkg::low_power_crystal_mode)
                   | (mode == lpbw_pkg::standard_crystal_mode)
                   | (mode == lpbw_pkg::high_speed_crystal_mode);
    endfunction : is_crystal

    function automatic logic is_rc(input logic [2:0] mode);
        is_rc = (mode == lpbw_pkg::external_rc_osc_mode)
              | (mode == lpbw_pkg::internal_rc_osc_mode);
    endfunction : is_rc

    // Register state
    logic       tx_q;
    logic       rx_q;
    logic [5:0] port_out_q;
    logic [5:0] dir_q;
    logic [5:0] pu_en_q;
    logic [5:0] ioc_en_q;
    logic [7:0] cfg_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [5:0] pin_q;
    logic [5:0] pin_prev_q;
    logic       ack_q;
    logic [31:0] dat_q;

    // Divider
    // Only the receive bit runs off its enable pulse; the divided clock only feeds pin four
    logic instr_clk_w;
    logic instr_en_w;

    lpbw_clk_div u_div (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .instr_clk_o (instr_clk_w),
        .instr_en_o  (instr_en_w)
    );

    // Bus decode
    // Ack low in the request term stops a held request being taken twice
    wire       req_w     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire       wr_w      = req_w & wb_we_i & wb_sel_i[0];
    wire [5:0] idx_w     = wb_adr_i[7:2];
    wire [7:0] wd_w      = wb_dat_i[7:0];
    wire       wr_port_w = wr_w & (idx_w == lpbw_pkg::IDX_PORT);
    wire       wr_dir_w  = wr_w & (idx_w == lpbw_pkg::IDX_DIR);
    wire       wr_pu_w   = wr_w & (idx_w == lpbw_pkg::IDX_PU);
    wire       wr_ioc_w  = wr_w & (idx_w == lpbw_pkg::IDX_IOC);
    wire       wr_cfg_w  = wr_w & (idx_w == lpbw_pkg::IDX_CFG);
    wire       wr_stat_w = wr_w & (idx_w == lpbw_pkg::IDX_STAT);
    wire       wr_mask_w = wr_w & (idx_w == lpbw_pkg::IDX_MASK);

    // Configuration fields
    wire [2:0] osc_mode_w = cfg_q[lpbw_pkg::CFG_OSC_MSB:lpbw_pkg::CFG_OSC_LSB];
    wire [1:0] pin2_fn_w  = cfg_q[lpbw_pkg::CFG_FN_MSB:lpbw_pkg::CFG_FN_LSB];
    wire       master_clear_n_en_w  = cfg_q[lpbw_pkg::CFG_MASTER_CLEAR_N_BIT];
    wire       rise_w     = cfg_q[lpbw_pkg::CFG_EDGE_BIT];
    wire       xtal_w     = is_crystal(osc_mode_w);
    wire       instr_clock_out_w   = is_rc(osc_mode_w) & cfg_q[lpbw_pkg::CFG_INSTR_CLOCK_OUT];
    wire       internal_rc_osc_mode_w    = (osc_mode_w == lpbw_pkg::internal_rc_osc_mode);

    // Per-pin general I/O availability
    wire [5:0] gpio_w;
    assign gpio_w[0] = 1'b1;
    assign gpio_w[1] = 1'b1;
    assign gpio_w[lpbw_pkg::PIN_EXT_INT] = (pin2_fn_w == lpbw_pkg::fn_gpio);
    assign gpio_w[lpbw_pkg::PIN_MASTER_CLEAR_N]    = ~master_clear_n_en_w;
    assign gpio_w[lpbw_pkg::PIN_XTAL]    = ~xtal_w & ~instr_clock_out_w;
    assign gpio_w[lpbw_pkg::PIN_OSC_IN]  = internal_rc_osc_mode_w;

    // Pin drive, enable and pull-up decisions
    wire [5:0] pin_out_d;
    wire [5:0] pin_oe_n_d;
    wire [5:0] pin_pu_d;

    genvar g;
    generate
        for (g = 0; g < lpbw_pkg::NUM_PINS; g++) begin : g_pin
            if (g == lpbw_pkg::PIN_XTAL) begin : g_instr_clock_out
                // RC modes can put the instruction clock on this pin
                assign pin_out_d[g]  = instr_clock_out_w ? instr_clk_w : port_out_q[g];
                assign pin_oe_n_d[g] = ~(instr_clock_out_w | (gpio_w[g] & ~dir_q[g]));
            end else if (g == lpbw_pkg::PIN_MASTER_CLEAR_N) begin : g_input_only
                // Input only, so master clear is never fought by our own driver
                assign pin_out_d[g]  = 1'b0;
                assign pin_oe_n_d[g] = 1'b1;
            end else begin : g_plain
                assign pin_out_d[g]  = port_out_q[g];
                assign pin_oe_n_d[g] = ~(gpio_w[g] & ~dir_q[g]);
            end
            if (g == lpbw_pkg::PIN_MASTER_CLEAR_N) begin : g_pu_master_clear_n
                assign pin_pu_d[g] = pu_en_q[g] | master_clear_n_en_w;
            end else begin : g_pu
                assign pin_pu_d[g] = pu_en_q[g] & lpbw_pkg::PU_PINS[g];
            end
        end
    endgenerate

    // Interrupt events
    wire [5:0] changed_w = (pin_q ^ pin_prev_q) & ioc_en_q & lpbw_pkg::IOC_PINS;
    wire       p2_now_w  = pin_q[lpbw_pkg::PIN_EXT_INT];
    wire       p2_was_w  = pin_prev_q[lpbw_pkg::PIN_EXT_INT];
    wire       p2_edge_w = rise_w ? (p2_now_w & ~p2_was_w) : (~p2_now_w & p2_was_w);
    wire       ext_ev_w  = (pin2_fn_w == lpbw_pkg::fn_ext_int) & p2_edge_w;
    wire       ioc_ev_w  = |changed_w;
    wire [1:0] ev_w      = {ioc_ev_w, ext_ev_w};
    // Set wins over a same-cycle write-one-to-clear
    wire [1:0] stat_d    = ev_w | (stat_q & ~(wr_stat_w ? wd_w[1:0] : 2'h0));
    // Interrupt level tracks the mask being written, not a cycle behind it
    wire [1:0] mask_d    = wr_mask_w ? wd_w[1:0] : mask_q;

    // Read mux; unmapped words read zero
    logic [7:0] rd_w;
    always_comb begin
        rd_w = 8'h00;
        case (idx_w)
            lpbw_pkg::IDX_PORT: rd_w = {tx_q, rx_q, pin_q};
            lpbw_pkg::IDX_DIR:  rd_w = {2'b00, dir_q};
            lpbw_pkg::IDX_PU:   rd_w = {2'b00, pu_en_q & lpbw_pkg::PU_PINS};
            lpbw_pkg::IDX_IOC:  rd_w = {2'b00, ioc_en_q & lpbw_pkg::IOC_PINS};
            lpbw_pkg::IDX_CFG:  rd_w = cfg_q;
            lpbw_pkg::IDX_STAT: rd_w = {6'h00, stat_q};
            lpbw_pkg::IDX_MASK: rd_w = {6'h00, mask_q};
            default:            rd_w = 8'h00;
        endcase
    end

    // Bus slave: one-cycle answer, writes land at the acknowledging edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_w;
            dat_q <= req_w ? {24'h00_0000, rd_w} : 32'h0000_0000;
        end
    end

    // Port register; transmit and receive bits ignore direction entirely
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_q       <= lpbw_pkg::PORT_RST[lpbw_pkg::PORT_TX_BIT];
            port_out_q <= lpbw_pkg::PORT_RST[5:0];
        end else if (wr_port_w) begin
            tx_q       <= wd_w[lpbw_pkg::PORT_TX_BIT];
            port_out_q <= wd_w[5:0];
        end
    end

    // Receive bit refreshed once per instruction cycle
    // Firmware polls no faster than this, so a faster sampler gains nothing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_q <= lpbw_pkg::PORT_RST[lpbw_pkg::PORT_RX_BIT];
        end else if (instr_en_w) begin
            rx_q <= bus_line_i;
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_q    <= lpbw_pkg::DIR_RST;
            pu_en_q  <= lpbw_pkg::PU_RST;
            ioc_en_q <= lpbw_pkg::IOC_RST;
            cfg_q    <= lpbw_pkg::CFG_RST;
            mask_q   <= lpbw_pkg::MASK_RST;
        end else begin
            if (wr_dir_w) begin
                dir_q <= wd_w[5:0];
            end
            if (wr_pu_w) begin
                pu_en_q <= wd_w[5:0];
            end
            if (wr_ioc_w) begin
                ioc_en_q <= wd_w[5:0];
            end
            if (wr_cfg_w) begin
                cfg_q <= wd_w;
            end
            if (wr_mask_w) begin
                mask_q <= wd_w[1:0];
            end
        end
    end

    // Pin sampling; reset seeds both stages from the pins so no false edge follows it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_q      <= pin_i;
            pin_prev_q <= pin_i;
        end else begin
            pin_q      <= pin_i;
            pin_prev_q <= pin_q;
        end
    end

    // Sticky interrupt status
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stat_q <= lpbw_pkg::STAT_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_line_oe_n_o      <= 1'b1;
            bus_line_o           <= 1'b0;
            bus_activity_out_o   <= 1'b1;
            pin_o                <= 6'h00;
            pin_oe_n_o           <= 6'h3F;
            pin_pullup_o         <= 6'h00;
            osc_output_en_o      <= 1'b0;
            osc_input_en_o       <= 1'b0;
            timer_ext_clock_in_o <= 1'b0;
            master_clear_n_o     <= 1'b1;
            irq_o                <= 1'b0;
            wake_o               <= 1'b0;
        end else begin
            // Open drain: a zero transmit bit pulls the line dominant
            bus_line_oe_n_o      <= tx_q;
            bus_line_o           <= 1'b0;
            // One flop of delay keeps the output glitch free; it never holds
            bus_activity_out_o   <= bus_line_i;
            pin_o                <= pin_out_d;
            pin_oe_n_o           <= pin_oe_n_d;
            pin_pullup_o         <= pin_pu_d;
            osc_output_en_o      <= xtal_w;
            osc_input_en_o       <= ~internal_rc_osc_mode_w;
            timer_ext_clock_in_o <= (pin2_fn_w == lpbw_pkg::fn_timer_clock) & p2_now_w;
            master_clear_n_o     <= ~(master_clear_n_en_w & ~pin_q[lpbw_pkg::PIN_MASTER_CLEAR_N]);
            irq_o                <= |(stat_d & mask_d);
            // Any event wakes the core, independent of the mask
            wake_o               <= |ev_w;
        end
    end

    assign wb_ack_o   = ack_q;
    assign wb_dat_o   = dat_q;

endmodule : lpbw_port

`default_nettype wire

// ==== testbench/lpbw_port_props.sv ====
// Concurrent checks on the port block's bus, pins and register answers
`timescale 1ns/1ps
`default_nettype none

module lpbw_port_props (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        bus_line_i,
    input wire logic        bus_line_oe_n_o,
    input wire logic        bus_activity_out_o,
    input wire logic [5:0]  pin_oe_n_o,
    input wire logic [5:0]  pin_pullup_o,
    input wire logic        osc_output_en_o,
    input wire logic        osc_input_en_o,
    input wire logic        master_clear_n_o
);
    logic       port_sel;
    logic       port_wr;
    logic       port_rd_ack;
    logic       bus_q;
    logic [3:0] stable_q;
    logic [3:0] stable_d;

    assign port_sel    = wb_adr_i[7:2] == lpbw_pkg::IDX_PORT;
    assign port_wr     = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && port_sel;
    assign port_rd_ack = wb_ack_o && !wb_we_i && port_sel;
    // Reads are judged only once the once-per-instruction sampler has surely caught up
    assign stable_d    = (stable_q == 4'hF) ? stable_q : stable_q + 4'h1;

    always_ff @(posedge clk_i) begin
        bus_q <= bus_line_i;
        if (!rst_n_i || bus_line_i != bus_q) begin
            stable_q <= 4'h0;
        end else begin
            stable_q <= stable_d;
        end
    end

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_tx_lands;
        ##2 bus_line_oe_n_o == $past(wb_dat_i[7], 2);
    endsequence

    AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_take |=> wb_ack_o) else $error("request not answered next cycle");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_TX_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        port_wr |-> s_tx_lands) else $error("bus drive does not follow transmit bit");
    AST_TX_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(bus_line_oe_n_o) |-> $past(port_wr, 2)) else $error("bus drive moved without port write");
    AST_RX_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        port_rd_ack && stable_q >= 4'd8 |-> wb_dat_o[6] == bus_line_i) else $error("receive bit stale");
    AST_ACT_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> bus_activity_out_o == $past(bus_line_i)) else $error("activity output not following");
    AST_RST_IDLE: assert property (@(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> bus_line_oe_n_o && !wb_ack_o) else $error("reset leaves bus driven");
    AST_MASTER_CLEAR_N_PU: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !master_clear_n_o |-> pin_pullup_o[3] && pin_oe_n_o[3]) else $error("master clear without pull-up");
    AST_OSC_PAIR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        osc_output_en_o |-> osc_input_en_o) else $error("crystal output without oscillator input");
endmodule : lpbw_port_props

`default_nettype wire

// ==== testbench/lpbw_bus_node.sv ====
// Far-side bus node and the wired line it shares with the block
`timescale 1ns/1ps
`default_nettype none

module lpbw_bus_node (
    // Line drivers
    input  wire logic dut_oe_n_i,
    input  wire logic dom_i,
    // Resolved line
    output logic      bus_o
);
    // Pull-up keeps the line recessive unless some node pulls it low
    assign bus_o = dut_oe_n_i & ~dom_i;
endmodule : lpbw_bus_node

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the bus transceiver port block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk_i;
    logic        rst_n_i;
    logic        wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [7:0]  clk_samp;
    logic [31:0] wb_wdat, wb_rdat;
    logic        bus_level, bus_oe_n, bus_act, node_dom;
    logic [5:0]  base_pins, pins, pin_out, pin_oe_n, pullups;
    logic        osc_out_en, osc_in_en, tmr_clk, master_clear_n_n, irq, wake, wake_seen;
    logic        tx, dom;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int          wsel, n, num_errors, check_count;

    lpbw_port dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .bus_line_i(bus_level), .bus_line_o(), .bus_line_oe_n_o(bus_oe_n), .bus_activity_out_o(bus_act),
        .pin_i(pins), .pin_o(pin_out), .pin_oe_n_o(pin_oe_n), .pin_pullup_o(pullups),
        .osc_output_en_o(osc_out_en), .osc_input_en_o(osc_in_en), .timer_ext_clock_in_o(tmr_clk),
        .master_clear_n_o(master_clear_n_n), .irq_o(irq), .wake_o(wake));
    lpbw_bus_node u_node (.dut_oe_n_i(bus_oe_n), .dom_i(node_dom), .bus_o(bus_level));

    always_comb begin
        pins       = base_pins;
        pins[wsel] = bus_act;
    end

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_sel  <= 4'hF;
        wb_adr  <= {idx, 2'b00};
        wb_wdat <= {24'h0000_00, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            $display("ERROR %0t: no ack", $time);
            results();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
    endtask : wb

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] msk);
        exp_q.push_back({exp, msk});
        wb(idx, 1'b0, 8'h00);
    endtask : rd

    task automatic bus_pulse();
        node_dom <= 1'b1;
        repeat (6) @(posedge clk_i);
        node_dom <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : bus_pulse

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Read answers are judged against the oldest note at the ack edge
    always @(posedge clk_i) begin
        if (wake === 1'b1) begin
            wake_seen <= 1'b1;
        end
        if (wb_ack === 1'b1 && wb_we === 1'b0) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR %0t: unexpected read answer", $time);
            end else begin
                e = exp_q.pop_front();
                check(wb_rdat[7:0] & e[7:0], e[15:8] & e[7:0]);
            end
        end
    end

    initial begin
        #100000;
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end

    initial begin
        rst_n_i   = 1'b0;
        wb_cyc    = 1'b0;
        wb_stb    = 1'b0;
        wb_we     = 1'b0;
        wb_sel    = 4'h0;
        clk_samp  = 8'h00;
        wb_adr    = 8'h00;
        wb_wdat   = 32'h0000_0000;
        node_dom  = 1'b0;
        base_pins = 6'h08;
        wake_seen = 1'b0;
        wsel      = 0;
        void'($urandom(32'h5950));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(lpbw_pkg::IDX_PORT, 8'hC0, 8'hC0);
        rd(6'h3F, 8'h00, 8'hFF);
        $display("test reset done");
        wb(lpbw_pkg::IDX_DIR, 1'b1, 8'h00);
        for (int i = 0; i < 10; i++) begin
            tx = 1'($urandom);
            dom = 1'($urandom);
            node_dom <= dom;
            wb(lpbw_pkg::IDX_PORT, 1'b1, {tx, 7'h40});
            repeat (8) @(posedge clk_i);
            rd(lpbw_pkg::IDX_PORT, {tx, tx & ~dom, 6'h00}, 8'hC0);
        end
        node_dom <= 1'b0;
        wb(lpbw_pkg::IDX_PORT, 1'b1, 8'hDF);
        repeat (2) @(posedge clk_i);
        check({2'b00, pin_out & ~pin_oe_n}, 8'h07);
        check({2'b00, pin_oe_n}, 8'h38);
        wb(lpbw_pkg::IDX_PORT, 1'b1, 8'hC0);
        wb(lpbw_pkg::IDX_DIR, 1'b1, 8'h3F);
        $display("test bus bits done");
        wb(lpbw_pkg::IDX_PU, 1'b1, 8'hFF);
        rd(lpbw_pkg::IDX_PU, 8'h0B, 8'h3F);
        check({2'b00, pullups}, 8'h0B);
        for (int m = 0; m < 5; m++) begin
            wb(lpbw_pkg::IDX_CFG, 1'b1, 8'(m));
            repeat (2) @(posedge clk_i);
            check({6'h00, osc_out_en, osc_in_en}, {6'h00, m < 3, m != 4});
        end
        for (int m = 3; m < 5; m++) begin
            wb(lpbw_pkg::IDX_CFG, 1'b1, 8'(m + 16));
            n = 0;
            repeat (8) begin
                @(posedge clk_i);
                n += pin_out[4];
                clk_samp = {clk_samp[6:0], pin_out[4]};
            end
            check(8'(n), 8'h04);
            check(clk_samp ^ {clk_samp[5:0], clk_samp[7:6]}, 8'hFF);
        end
        wb(lpbw_pkg::IDX_CFG, 1'b1, 8'h24);
        base_pins[2] <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({7'h00, tmr_clk}, 8'h01);
        wb(lpbw_pkg::IDX_PU, 1'b1, 8'h00);
        wb(lpbw_pkg::IDX_CFG, 1'b1, 8'h0C);
        base_pins <= 6'h00;
        repeat (3) @(posedge clk_i);
        check({6'h00, master_clear_n_n, pullups[3]}, 8'h01);
        base_pins <= 6'h08;
        $display("test pin functions done");
        wb(lpbw_pkg::IDX_CFG, 1'b1, 8'hC4);
        wb(lpbw_pkg::IDX_IOC, 1'b1, 8'h0B);
        wb(lpbw_pkg::IDX_MASK, 1'b1, 8'h03);
        for (int p = 0; p < 4; p++) begin
            wsel <= p;
            repeat (4) @(posedge clk_i);
            wb(lpbw_pkg::IDX_STAT, 1'b1, 8'h03);
            wake_seen <= 1'b0;
            bus_pulse();
            check({6'h00, wake_seen, irq}, 8'h03);
            rd(lpbw_pkg::IDX_STAT, (p == 2) ? 8'h01 : 8'h02, 8'h03);
            wb(lpbw_pkg::IDX_STAT, 1'b1, 8'h03);
            repeat (2) @(posedge clk_i);
            check({7'h00, irq}, 8'h00);
        end
        wb(lpbw_pkg::IDX_MASK, 1'b1, 8'h00);
        wake_seen <= 1'b0;
        bus_pulse();
        check({6'h00, wake_seen, irq}, 8'h02);
        rd(lpbw_pkg::IDX_STAT, 8'h02, 8'h03);
        wb(lpbw_pkg::IDX_STAT, 1'b1, 8'h02);
        rd(lpbw_pkg::IDX_STAT, 8'h00, 8'h03);
        $display("test wake done");
        repeat (4) @(posedge clk_i);
        results();
    end
endmodule : tb_top

bind lpbw_port lpbw_port_props u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_line_i(bus_line_i), .bus_line_oe_n_o(bus_line_oe_n_o),
    .bus_activity_out_o(bus_activity_out_o), .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o),
    .osc_output_en_o(osc_output_en_o), .osc_input_en_o(osc_input_en_o), .master_clear_n_o(master_clear_n_o));

`default_nettype wire
